// ==== core/rtco_trim.sv ====
// module: clock trim unit with correction pulse sequencer
`timescale 1ns/100ps
// Contract
// R1: 8-bit trim register, resets to zero
// R2: trim is two's complement, +127 to -128
// R3: rate select is oscillator control bit 6
// R4: normal rate corrects every four hours
// R5: fast rate corrects every eight minutes
// R6: add or remove pulses, oscillator untouched
// R7: normal rate: one pulse per minute
// R8: normal pulses from minute 00, spill over hours
// R9: fast rate: one pulse per second
// R10: fast pulses from second 00, spill over minutes
// R11: event output for every correction pulse
// R12: enabled interrupt pulse per correction
// R13: interrupt cleared by 128 Hz, 1-2 periods
// R14: trim and rate captured at each trigger
module rtco_trim (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // time base ticks
  input wire logic sec_tick,
  input wire logic min_tick,
  input wire logic hour_tick,
  input wire logic tick_128hz,
  // correction pulses to the prescaler
  output logic corr_add,
  output logic corr_remove,
  output logic corr_event,
  // interrupt pins
  output logic irq_out_a_n,
  output logic irq_out_b_n
);
  rtco_pkg::rtco_state_t st_ff;
  rtco_pkg::rtco_state_t nxt_st;
  logic trig;
  logic step;
  logic pulse;
  logic [7:0] abs_trim;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] trim_mag(input logic [7:0] v);
    // -128 gives 8'h80, a count of 128
    trim_mag = v[rtco_pkg::TRIM_SIGN_BIT] ? 8'(~v + 8'h01) : v;
  endfunction : trim_mag

  // ----------------------------------------
  // sequencer decode
  // ----------------------------------------
  always_comb begin
    abs_trim = trim_mag(st_ff.clock_trim_value);
    // R4 four-hour trigger
    // R5 eight-minute trigger
    if (st_ff.oscillator_control[rtco_pkg::RATE_SEL_BIT]) begin
      trig = min_tick && (st_ff.min_cnt == rtco_pkg::MIN_WRAP);
    end else begin
      trig = hour_tick && (st_ff.hour_cnt == rtco_pkg::HOUR_WRAP);
    end
    trig = trig && (abs_trim != 8'h00) && !st_ff.active;
    // R7 minute steps
    // R9 second steps
    step = st_ff.active && (st_ff.fast ? sec_tick : min_tick);
    pulse = trig || step;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.corr_add = 1'b0;
    nxt_st.corr_rem = 1'b0;
    if (ce) begin
      // R1 register writes
      if (reg_wr_en) begin
        case (reg_addr)
          rtco_pkg::TRIM_ADDR: nxt_st.clock_trim_value = reg_wr_data;
          rtco_pkg::OSC_ADDR: nxt_st.oscillator_control = reg_wr_data;
          rtco_pkg::IRQ_EN_A_ADDR: nxt_st.irq_en_a = reg_wr_data;
          rtco_pkg::IRQ_EN_B_ADDR: nxt_st.irq_en_b = reg_wr_data;
          default: nxt_st.rd_data = st_ff.rd_data;
        endcase
      end
      if (reg_rd_en) begin
        case (reg_addr)
          rtco_pkg::TRIM_ADDR: nxt_st.rd_data = st_ff.clock_trim_value;
          rtco_pkg::OSC_ADDR: nxt_st.rd_data = st_ff.oscillator_control;
          rtco_pkg::IRQ_EN_A_ADDR: nxt_st.rd_data = st_ff.irq_en_a;
          rtco_pkg::IRQ_EN_B_ADDR: nxt_st.rd_data = st_ff.irq_en_b;
          default: nxt_st.rd_data = 8'h00;
        endcase
      end
      if (hour_tick) begin
        nxt_st.hour_cnt = st_ff.hour_cnt + 2'h1;
      end
      if (min_tick) begin
        nxt_st.min_cnt = st_ff.min_cnt + 3'h1;
      end
      if (trig) begin
        // R14 capture at trigger
        // R3 rate latched from bit 6
        nxt_st.fast = st_ff.oscillator_control[rtco_pkg::RATE_SEL_BIT];
        // R2 signed trim
        nxt_st.add = !st_ff.clock_trim_value[rtco_pkg::TRIM_SIGN_BIT];
        // R8 first pulse at 00, count spills on
        // R10 same for seconds
        nxt_st.remain = abs_trim - 8'h01;
        nxt_st.active = (abs_trim != 8'h01);
      end else if (step) begin
        nxt_st.remain = st_ff.remain - 8'h01;
        nxt_st.active = (st_ff.remain != 8'h01);
      end
      if (pulse) begin
        // R6 pulse, never the oscillator
        nxt_st.corr_add = trig ? !st_ff.clock_trim_value[rtco_pkg::TRIM_SIGN_BIT] : st_ff.add;
        nxt_st.corr_rem = trig ? st_ff.clock_trim_value[rtco_pkg::TRIM_SIGN_BIT] : !st_ff.add;
      end
      // R13 128 hz clear, pulse new event wins
      if (st_ff.irq_a && tick_128hz) begin
        nxt_st.armed_a = 1'b1;
        nxt_st.irq_a = !st_ff.armed_a;
      end
      if (st_ff.irq_b && tick_128hz) begin
        nxt_st.armed_b = 1'b1;
        nxt_st.irq_b = !st_ff.armed_b;
      end
      // R12 enabled interrupt pulses
      if (pulse && st_ff.irq_en_a[rtco_pkg::TRIM_IRQ_EN_BIT]) begin
        nxt_st.irq_a = 1'b1;
        nxt_st.armed_a = 1'b0;
      end
      if (pulse && st_ff.irq_en_b[rtco_pkg::TRIM_IRQ_EN_BIT]) begin
        nxt_st.irq_b = 1'b1;
        nxt_st.armed_b = 1'b0;
      end
    end else begin
      // frozen: pulses hold their value
      nxt_st.corr_add = st_ff.corr_add;
      nxt_st.corr_rem = st_ff.corr_rem;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.clock_trim_value <= rtco_pkg::TRIM_RESET;
      st_ff.oscillator_control <= rtco_pkg::OSC_RESET;
      st_ff.irq_en_a <= rtco_pkg::IRQ_EN_RESET;
      st_ff.irq_en_b <= rtco_pkg::IRQ_EN_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rd_data = st_ff.rd_data;
  assign corr_add = st_ff.corr_add;
  assign corr_remove = st_ff.corr_rem;
  // R11 correction event
  assign corr_event = st_ff.corr_add || st_ff.corr_rem;
  assign irq_out_a_n = !st_ff.irq_a;
  assign irq_out_b_n = !st_ff.irq_b;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_trim_write;
    @(posedge core_clk) disable iff (!rst_n)
    ce && reg_wr_en && reg_addr == rtco_pkg::TRIM_ADDR
      |=> st_ff.clock_trim_value == $past(reg_wr_data);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost"); // R1

  property p_count;
    @(posedge core_clk) disable iff (!rst_n)
    ce && trig |=> st_ff.remain == $past(abs_trim) - 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("pulse count wrong"); // R2

  property p_rate;
    @(posedge core_clk) disable iff (!rst_n)
    ce && trig |=> st_ff.fast == $past(st_ff.oscillator_control[rtco_pkg::RATE_SEL_BIT]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate not captured"); // R3

  property p_normal_step;
    @(posedge core_clk) disable iff (!rst_n)
    ce && st_ff.active && !st_ff.fast && min_tick |=> corr_event;
  endproperty
  a_normal_step: assert property (p_normal_step) else $error("minute pulse missing"); // R7

  property p_fast_step;
    @(posedge core_clk) disable iff (!rst_n)
    ce && st_ff.active && st_ff.fast && sec_tick |=> corr_event;
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("second pulse missing"); // R9

  property p_exclusive;
    @(posedge core_clk) disable iff (!rst_n)
    !(corr_add && corr_remove);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("add and remove together"); // R6

  property p_irq_a;
    @(posedge core_clk) disable iff (!rst_n)
    ce && pulse && st_ff.irq_en_a[rtco_pkg::TRIM_IRQ_EN_BIT] |=> !irq_out_a_n ##0 corr_event;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a missing"); // R12

  property p_irq_b;
    @(posedge core_clk) disable iff (!rst_n)
    ce && pulse && st_ff.irq_en_b[rtco_pkg::TRIM_IRQ_EN_BIT] |=> !irq_out_b_n ##0 corr_event;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b missing"); // R12

  property p_irq_hold;
    @(posedge core_clk) disable iff (!rst_n)
    ce && !irq_out_a_n && !st_ff.armed_a && tick_128hz |=> !irq_out_a_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq cleared too soon"); // R13

  property p_capture;
    @(posedge core_clk) disable iff (!rst_n)
    ce && st_ff.active && !pulse |=> $stable(st_ff.remain) && $stable(st_ff.add);
  endproperty
  a_capture: assert property (p_capture) else $error("sequence disturbed"); // R14
endmodule : rtco_trim

// ==== include/rtco_pkg.sv ====
// package: registers, fields and state of the clock trim unit
package rtco_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] TRIM_ADDR = 8'h24;
  localparam logic [7:0] OSC_ADDR = 8'h25;
  localparam logic [7:0] IRQ_EN_A_ADDR = 8'h29;
  localparam logic [7:0] IRQ_EN_B_ADDR = 8'h2a;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] OSC_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RATE_SEL_BIT = 6;
  localparam int TRIM_IRQ_EN_BIT = 5;
  localparam int TRIM_SIGN_BIT = 7;
  // ----------------------------------------
  // period counts
  // ----------------------------------------
  localparam int NORMAL_HOURS = 4;
  localparam int FAST_MINUTES = 8;
  localparam logic [1:0] HOUR_WRAP = 2'h3;
  localparam logic [2:0] MIN_WRAP = 3'h7;

  typedef struct packed {
    logic [7:0] clock_trim_value;
    logic [7:0] oscillator_control;
    logic [7:0] irq_en_a;
    logic [7:0] irq_en_b;
    logic [1:0] hour_cnt;
    logic [2:0] min_cnt;
    logic active;
    logic fast;
    logic add;
    logic [7:0] remain;
    logic corr_add;
    logic corr_rem;
    logic irq_a;
    logic irq_b;
    logic armed_a;
    logic armed_b;
    logic [7:0] rd_data;
  } rtco_state_t;
endpackage : rtco_pkg

// ==== tb/rtco_host.sv ====
// host model driving the register port
`timescale 1ns/100ps
module rtco_host (
  // clock
  core_clk,
  // register port
  reg_addr,
  reg_wr_en,
  reg_wr_data,
  reg_rd_en
);
  input wire logic core_clk;
  output logic [7:0] reg_addr = 8'h00;
  output logic reg_wr_en = 1'b0;
  output logic [7:0] reg_wr_data = 8'h00;
  output logic reg_rd_en = 1'b0;
  // one access, held across one sampling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = w;
    reg_rd_en = ~w;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    // released data shows no stale value
    reg_wr_data = ~d;
  endtask : acc
endmodule : rtco_host

// ==== tb/rtco_trim_tb_top.sv ====
// testbench of the clock trim unit
`timescale 1ns/100ps
module rtco_trim_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sec_tick = 1'b0;
  logic min_tick = 1'b0;
  logic hour_tick = 1'b0;
  logic tick_128hz = 1'b0;
  logic ce = 1'b1;
  logic en_a = 1'b0;
  logic en_b = 1'b0;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic reg_wr_en, reg_rd_en, corr_add, corr_remove, corr_event, irq_out_a_n, irq_out_b_n;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int fails = 0, cmp_count = 0, cyc = 0;
  int n_add, n_rem, n_ev, n_ia, n_ib;
  always #2.5 core_clk = ~core_clk;
  rtco_host rtco_host_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));
  rtco_trim rtco_trim_i (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .sec_tick(sec_tick),
    .min_tick(min_tick), .hour_tick(hour_tick), .tick_128hz(tick_128hz),
    .corr_add(corr_add), .corr_remove(corr_remove), .corr_event(corr_event),
    .irq_out_a_n(irq_out_a_n), .irq_out_b_n(irq_out_b_n));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // watcher: read data one cycle after the strobe, pulse counts
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd_en;
    if (rd_d) chk(reg_rd_data, exp_q.pop_front());
    if (corr_add === 1'b1) n_add <= n_add + 1;
    if (corr_remove === 1'b1) n_rem <= n_rem + 1;
    if (corr_event === 1'b1) n_ev <= n_ev + 1;
    if (irq_out_a_n === 1'b0) n_ia <= n_ia + 1;
    if (irq_out_b_n !== 1'b1) n_ib <= n_ib + 1;
    // hang guard, well above the planned run
    if (cyc == 40000) begin
      fails++;
      give_verdict;
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rtco_host_i.acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    rtco_host_i.acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse(input int w);
    @(negedge core_clk);
    {tick_128hz, hour_tick, min_tick, sec_tick} = 4'(1 << w);
    @(negedge core_clk);
    {tick_128hz, hour_tick, min_tick, sec_tick} = 4'h0;
    @(negedge core_clk);
    // frozen cycle: the same tick again must change nothing
    ce = 1'b0;
    {tick_128hz, hour_tick, min_tick, sec_tick} = 4'(1 << w);
    @(negedge core_clk);
    ce = 1'b1;
    {tick_128hz, hour_tick, min_tick, sec_tick} = 4'h0;
  endtask : pulse
  // one full correction sequence at one rate
  task automatic run(input logic fast, input logic [7:0] t);
    logic [7:0] n;
    logic ia;
    logic ib;
    n = t[7] ? 8'h00 - t : t;
    ia = en_a && (n != 8'h00);
    ib = en_b && (n != 8'h00);
    wr(rtco_pkg::OSC_ADDR, fast ? 8'h40 : 8'h00);
    wr(rtco_pkg::TRIM_ADDR, t);
    rd(rtco_pkg::TRIM_ADDR, t);
    {n_add, n_rem, n_ev, n_ia, n_ib} = '0;
    repeat (fast ? rtco_pkg::FAST_MINUTES : rtco_pkg::NORMAL_HOURS) pulse(fast ? 1 : 2);
    // late write waits for the next trigger
    wr(rtco_pkg::TRIM_ADDR, ~t);
    repeat (130) pulse(fast ? 0 : 1);
    pulse(3);
    chk({7'h0, irq_out_a_n}, {7'h0, !ia});
    chk({7'h0, irq_out_b_n}, {7'h0, !ib});
    pulse(3);
    chk(8'(n_add), t[7] ? 8'h00 : n);
    chk(8'(n_rem), t[7] ? n : 8'h00);
    chk(8'(n_ev), n);
    chk({7'h0, n_ia != 0}, {7'h0, ia});
    chk({7'h0, n_ib != 0}, {7'h0, ib});
    chk({7'h0, irq_out_a_n}, 8'h01);
    chk({7'h0, irq_out_b_n}, 8'h01);
  endtask : run
  initial begin
    int v;
    v = $urandom(58);
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    rd(rtco_pkg::TRIM_ADDR, 8'h00);
    rd(rtco_pkg::OSC_ADDR, 8'h00);
    rd(8'h30, 8'h00);
    wr(rtco_pkg::IRQ_EN_A_ADDR, 8'h20);
    en_a = 1'b1;
    rd(rtco_pkg::IRQ_EN_A_ADDR, 8'h20);
    run(1'b1, 8'h02);
    run(1'b1, 8'h80);
    repeat (2) begin
      v = $urandom_range(1, 70);
      run(1'b1, $urandom_range(0, 1) ? 8'(v) : 8'(-v));
    end
    run(1'b1, 8'h00);
    wr(rtco_pkg::IRQ_EN_B_ADDR, 8'h20);
    en_b = 1'b1;
    run(1'b0, 8'hff);
    wr(rtco_pkg::IRQ_EN_A_ADDR, 8'h00);
    en_a = 1'b0;
    run(1'b0, 8'h80);
    // second reset after the last run brings the registers back
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    rd(rtco_pkg::TRIM_ADDR, rtco_pkg::TRIM_RESET);
    rd(rtco_pkg::IRQ_EN_B_ADDR, rtco_pkg::IRQ_EN_RESET);
    // let the last read reach the watcher
    repeat (2) @(negedge core_clk);
    give_verdict;
  end
endmodule : rtco_trim_tb_top
